// ### adc_port_defines.svh
`ifndef ADC_PORT_DEFINES_SVH
`define ADC_PORT_DEFINES_SVH
`define RESULT_BITS 14
`define FRAME_EDGES 5'h10
`define FIRST_BIT_EDGE 5'h03
`define LAST_BIT_EDGE 5'h10
`define NAP_STROBES 3'h2
`define SLEEP_STROBES 3'h4
`endif

// ### adc_port_pkg.sv
package adc_port_pkg;
  typedef enum logic [3:0] {
    ST_TRACK = 4'h1,
    ST_CONVERT = 4'h2,
    ST_NAP = 4'h4,
    ST_SLEEP = 4'h8
  } mode_e;
  typedef struct packed {
    mode_e mode;
    logic [4:0] edge_cnt;
    logic [2:0] strobe_cnt;
    logic [13:0] shreg;
    logic serial_result_out;
    logic sdo_oe;
    logic strobe_s1;
    logic strobe_s2;
    logic strobe_d;
    logic sck_s1;
    logic sck_s2;
    logic sck_d;
  } state_s;
endpackage

// ### adc_serial_conversion_port.sv
`timescale 1ns/1ps
`include "adc_port_defines.svh"
module adc_serial_conversion_port (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic CONVERSION_STROBE_IN,
  input wire logic SHIFT_CLK_IN,
  input wire logic [13:0] SAMPLE_IN,
  output logic SERIAL_RESULT_OUT,
  output logic SERIAL_RESULT_OE_OUT,
  output logic NAP_OUT,
  output logic SLEEP_OUT,
  output logic BUSY_OUT
);
  adc_port_pkg::state_s state_reg;
  adc_port_pkg::state_s state_next;
  logic strobe_rise;
  logic sck_rise;

  assign strobe_rise = state_reg.strobe_s2 & ~state_reg.strobe_d;
  assign sck_rise = state_reg.sck_s2 & ~state_reg.sck_d;

  // both power-down states share the same wake and release behaviour
  function automatic logic is_powered_down(input adc_port_pkg::mode_e m);
    return m == adc_port_pkg::ST_NAP || m == adc_port_pkg::ST_SLEEP;
  endfunction

  always_comb begin
    state_next = state_reg;
    // only the strobe rise is used, so its duty cycle is free
    state_next.strobe_s1 = CONVERSION_STROBE_IN;
    state_next.strobe_s2 = state_reg.strobe_s1;
    state_next.strobe_d = state_reg.strobe_s2;
    state_next.sck_s1 = SHIFT_CLK_IN;
    state_next.sck_s2 = state_reg.sck_s1;
    state_next.sck_d = state_reg.sck_s2;
    case (state_reg.mode)
      adc_port_pkg::ST_TRACK, adc_port_pkg::ST_NAP,
      adc_port_pkg::ST_SLEEP: begin
        if (sck_rise) begin
          state_next.strobe_cnt = 3'h0;
          if (state_reg.mode != adc_port_pkg::ST_TRACK) begin
            state_next.mode = adc_port_pkg::ST_TRACK;
          end
        end else if (strobe_rise) begin
          if (state_reg.strobe_cnt == 3'h0 &&
              state_reg.mode == adc_port_pkg::ST_TRACK) begin
            state_next.mode = adc_port_pkg::ST_CONVERT;
            state_next.edge_cnt = 5'h00;
            state_next.shreg = SAMPLE_IN;
          end
          if (state_reg.strobe_cnt != 3'h7) begin
            state_next.strobe_cnt = state_reg.strobe_cnt + 3'h1;
          end
          if (state_reg.strobe_cnt + 3'h1 == `SLEEP_STROBES) begin
            state_next.mode = adc_port_pkg::ST_SLEEP;
          end else if (state_reg.strobe_cnt + 3'h1 == `NAP_STROBES) begin
            state_next.mode = adc_port_pkg::ST_NAP;
          end
        end
      end
      adc_port_pkg::ST_CONVERT: begin
        if (strobe_rise && state_reg.edge_cnt == 5'h00) begin
          state_next.strobe_cnt = state_reg.strobe_cnt + 3'h1;
          if (state_reg.strobe_cnt + 3'h1 == `NAP_STROBES) begin
            state_next.mode = adc_port_pkg::ST_NAP;
          end
        end
        if (sck_rise) begin
          state_next.strobe_cnt = 3'h0;
          state_next.edge_cnt = state_reg.edge_cnt + 5'h01;
          if (state_reg.edge_cnt + 5'h01 >= `FIRST_BIT_EDGE &&
              state_reg.edge_cnt + 5'h01 <= `LAST_BIT_EDGE) begin
            state_next.serial_result_out = state_reg.shreg[13];
            state_next.shreg = {state_reg.shreg[12:0], 1'b0};
            state_next.sdo_oe = 1'b1;
          end
          if (state_reg.edge_cnt + 5'h01 == `FRAME_EDGES) begin
            state_next.mode = adc_port_pkg::ST_TRACK;
          end
        end
      end
      default: begin
        state_next.mode = adc_port_pkg::ST_TRACK;
      end
    endcase
    if (state_reg.sdo_oe && sck_rise &&
        state_reg.edge_cnt + 5'h01 > `LAST_BIT_EDGE) begin
      state_next.sdo_oe = 1'b0;
      state_next.serial_result_out = 1'b0;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_reg <= '{mode: adc_port_pkg::ST_TRACK, default: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      SERIAL_RESULT_OUT <= 1'b0;
      SERIAL_RESULT_OE_OUT <= 1'b0;
      NAP_OUT <= 1'b0;
      SLEEP_OUT <= 1'b0;
      BUSY_OUT <= 1'b0;
    end else begin
      SERIAL_RESULT_OUT <= state_next.serial_result_out;
      SERIAL_RESULT_OE_OUT <= state_next.sdo_oe;
      NAP_OUT <= state_next.mode == adc_port_pkg::ST_NAP;
      SLEEP_OUT <= state_next.mode == adc_port_pkg::ST_SLEEP;
      BUSY_OUT <= state_next.mode == adc_port_pkg::ST_CONVERT;
    end
  end

  sequence s_start;
    strobe_rise && state_reg.mode == adc_port_pkg::ST_TRACK &&
      state_reg.strobe_cnt == 3'h0 && !sck_rise;
  endsequence

  a_conversion_strobe_start: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    s_start |=> state_reg.mode == adc_port_pkg::ST_CONVERT)
    else $error("strobe did not start conversion");
  a_strobe_ignored: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    state_reg.mode == adc_port_pkg::ST_CONVERT && strobe_rise && !sck_rise
    && state_reg.edge_cnt != 5'h00 |=> $stable(state_reg.edge_cnt))
    else $error("strobe disturbed a running conversion");
  a_frame_end: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    state_reg.edge_cnt > `FRAME_EDGES |-> 1'b0)
    else $error("frame ran past sixteen edges");
  a_edge_step: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    state_reg.mode == adc_port_pkg::ST_CONVERT && sck_rise |=>
    state_reg.edge_cnt == $past(state_reg.edge_cnt) + 5'h01)
    else $error("shift edge did not advance conversion");
  a_first_bit: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    state_reg.mode == adc_port_pkg::ST_CONVERT && sck_rise &&
    state_reg.edge_cnt == 5'h02 |=> state_reg.sdo_oe &&
    state_reg.serial_result_out == $past(state_reg.shreg[13]))
    else $error("msb not driven on third edge");
  a_hiz_idle: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    state_reg.sdo_oe |-> state_reg.edge_cnt >= `FIRST_BIT_EDGE)
    else $error("output driven outside result bits");
  a_hiz_last: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    state_reg.sdo_oe && sck_rise && state_reg.edge_cnt == `LAST_BIT_EDGE
    |=> !state_reg.sdo_oe)
    else $error("output not released after last bit");
  a_nap_entry: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    strobe_rise && !sck_rise && state_reg.strobe_cnt == 3'h1 &&
    state_reg.mode != adc_port_pkg::ST_SLEEP |=>
    state_reg.mode == adc_port_pkg::ST_NAP)
    else $error("two strobes did not enter nap");
  a_sleep_entry: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    strobe_rise && !sck_rise && state_reg.strobe_cnt == 3'h3 |=>
    state_reg.mode == adc_port_pkg::ST_SLEEP)
    else $error("four strobes did not enter sleep");
  a_wake: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    sck_rise && is_powered_down(state_reg.mode) |=>
    state_reg.mode == adc_port_pkg::ST_TRACK)
    else $error("shift edge did not wake device");

  // a shift edge inside the result window of a running conversion
  sequence s_bit_edge;
    state_reg.mode == adc_port_pkg::ST_CONVERT && sck_rise &&
      state_reg.edge_cnt >= 5'h03 && state_reg.edge_cnt < `LAST_BIT_EDGE;
  endsequence

  // the port is parked in one of the power-down states
  sequence s_asleep;
    is_powered_down(state_reg.mode);
  endsequence

  a_bit_shift: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    s_bit_edge |=> state_reg.sdo_oe &&
    state_reg.serial_result_out == $past(state_reg.shreg[13]))
    else $error("result bit not advanced on shift edge");
  a_sample_capture: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    s_start |=> state_reg.shreg == $past(SAMPLE_IN))
    else $error("sample not captured at conversion start");
  a_hiz_asleep: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    s_asleep |-> !state_reg.sdo_oe)
    else $error("output driven in power-down");
  a_pin_match: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    SERIAL_RESULT_OE_OUT == state_reg.sdo_oe &&
    (!SERIAL_RESULT_OE_OUT || SERIAL_RESULT_OUT == state_reg.serial_result_out))
    else $error("output pins differ from shift state");
  a_strobe_clear: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    sck_rise |=> state_reg.strobe_cnt == 3'h0)
    else $error("shift edge did not clear strobe count");
  a_busy_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    BUSY_OUT == (state_reg.mode == adc_port_pkg::ST_CONVERT))
    else $error("busy flag differs from mode");
  a_nap_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    NAP_OUT == (state_reg.mode == adc_port_pkg::ST_NAP))
    else $error("nap flag differs from mode");
  a_sleep_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    SLEEP_OUT == (state_reg.mode == adc_port_pkg::ST_SLEEP))
    else $error("sleep flag differs from mode");
endmodule

// ### host_serial_model.sv
`timescale 1ns/1ps
module host_serial_model (
  input wire logic clk_in,
  input wire logic sdo_in,
  input wire logic oe_in,
  output logic strobe_out,
  output logic sck_out,
  output logic [16:0] data_word_out,
  output logic [16:0] oe_word_out
);
  logic last;
  logic line;
  initial begin
    strobe_out = 1'b0;
    sck_out = 1'b0;
    last = 1'b0;
  end
  // a released line shows the inverse of the last driven level
  always @(posedge clk_in) if (oe_in) last <= sdo_in;
  assign line = oe_in ? sdo_in : ~last;
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  // half a shift period wide, low phase far above the minimum
  task automatic strobe_pulse();
    strobe_out = 1'b1;
    wait_clk(8);
    strobe_out = 1'b0;
    wait_clk(8);
  endtask
  task automatic shift(input int n);
    repeat (n) begin
      sck_out = 1'b1;
      wait_clk(8);
      data_word_out = {data_word_out[15:0], line};
      oe_word_out = {oe_word_out[15:0], oe_in};
      sck_out = 1'b0;
      wait_clk(8);
    end
  endtask
endmodule

// ### tb_adc_serial_conversion_port.sv
`timescale 1ns/1ps
module tb_adc_serial_conversion_port;
  logic clk, rst, serial_result_out, oe, nap, sleep, busy, strobe, sck;
  logic [13:0] sample;
  logic [16:0] dword, oword;
  int error_cnt, num_checks, cycles;
  adc_serial_conversion_port i_adc_serial_conversion_port (
    .CLK_IN(clk), .RST_IN(rst), .CONVERSION_STROBE_IN(strobe),
    .SHIFT_CLK_IN(sck), .SAMPLE_IN(sample), .SERIAL_RESULT_OUT(serial_result_out),
    .SERIAL_RESULT_OE_OUT(oe), .NAP_OUT(nap), .SLEEP_OUT(sleep),
    .BUSY_OUT(busy));
  host_serial_model i_host_serial_model (.clk_in(clk), .sdo_in(serial_result_out),
    .oe_in(oe), .strobe_out(strobe), .sck_out(sck),
    .data_word_out(dword), .oe_word_out(oword));
  task automatic check(input string name, input logic [16:0] seen,
                       input logic [16:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic convert(input logic [13:0] s, input bit extra);
    sample = s;
    i_host_serial_model.strobe_pulse();
    check("busy", 17'(busy), 17'h1);
    i_host_serial_model.shift(5);
    if (extra) begin
      sample = ~s;
      i_host_serial_model.strobe_pulse();
    end
    i_host_serial_model.shift(12);
    check("result", {1'b0, dword[16:1] & 16'h3FFF}, 17'(s));
    check("enable", oword, 17'h07FFE);
    check("ob", {3'h0, dword[14:1] ^ 14'h2000}, 17'(s) ^ 17'h2000);
    check("idle", {busy, oe}, 17'h0);
  endtask
  task automatic test_frames();
    logic [13:0] tbl [5] = '{14'h1FFF, 14'h2000, 14'h0000, 14'h3FFF,
                             14'h1555};
    foreach (tbl[i]) convert(tbl[i], 1'b0);
    convert(14'h2AAA, 1'b1);
    $display("test frames done");
  endtask
  task automatic test_power();
    i_host_serial_model.strobe_pulse();
    i_host_serial_model.strobe_pulse();
    check("nap", {nap, sleep, oe}, 17'h4);
    i_host_serial_model.strobe_pulse();
    i_host_serial_model.strobe_pulse();
    check("sleep", {nap, sleep, oe}, 17'h2);
    i_host_serial_model.shift(17);
    check("wake", {nap, sleep, oe}, 17'h0);
    convert(14'h1234, 1'b0);
    $display("test power done");
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    rst = 1'b1;
    sample = 14'h0000;
    repeat (6) @(posedge clk);
    #2;
    rst = 1'b0;
    i_host_serial_model.wait_clk(2);
    check("reset", {oe, nap, sleep, busy}, 17'h0);
    $display("test reset done");
    test_frames();
    test_power();
    report_and_stop();
  end
endmodule
